//--- rtl/adc_conv_defs.svh
// Offsets, field positions, reset values and cycle counts of the conversion control block
// Operation
// - Control write aborts conversion, reinitialises sequencing
// - Control fields: channel, speed, trigger, power, mode, start
// - Channel codes map to inputs 0,1,2,4,3
// - Fast conversion lasts 78 clock periods
// - Slow conversion lasts 138 clock periods
// - Enabled trigger edge or event sets start flag
// - Power bit low keeps converter disabled
// - Single mode clears start flag at end
// - Continuous mode converts back to back while set
// - Start flag writable; triggers also set it
// - Start flag falling raises interrupt when enabled
// - Result register loads at each conversion end not hit by a control write in the same cycle
// - Source select bit routes interrupt line, resets 01h
// - Control register resets to zero
// - Triggers ignored while start flag is set
// - Halt forces power bit to zero
`ifndef ADC_CONV_DEFS_SVH
`define ADC_CONV_DEFS_SVH
`define ADDR_W 12
`define IDX_RESULT 8'hF0
`define IDX_CTRL 8'hF1
`define IDX_INTSEL 8'hF2
`define CTRL_RST 8'h00
`define INTSEL_RST 1'h1
`define CH_MSB 7
`define CH_LSB 5
`define SPEED_BIT 4
`define TRIG_EN_BIT 3
`define POWER_BIT 2
`define CONT_BIT 1
`define START_BIT 0
// 78 and 138 clock periods per conversion
`define FAST_CYC 8'h4E
`define SLOW_CYC 8'h8A
// 48 and 84 clock periods of sampling
`define FAST_SMP 8'h30
`define SLOW_SMP 8'h54
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

//--- rtl/adc_conv_pkg.sv
// Types of the conversion control block
`include "adc_conv_defs.svh"
package adc_conv_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b10
    } conv_state_t;

    typedef struct packed {
        logic [7:0] count;
    } timer_regs_t;

    typedef struct packed {
        conv_state_t state;
        logic [7:0] ctrl;
        logic [7:0] result;
        logic int_sel;
        logic trig_prev;
        logic aw_have;
        logic [`ADDR_W-1:0] aw_addr;
        logic w_have;
        logic [7:0] w_byte;
        logic w_en;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [2:0] channel;
        logic sample;
        logic busy;
        logic power;
        logic irq;
    } ctl_regs_t;
endpackage

//--- rtl/conv_timer.sv
// Cycle counter that times one conversion and its sampling phase
`timescale 1ns/1ps
`include "adc_conv_defs.svh"
module conv_timer
    import adc_conv_pkg::*;
(
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic run_in,
    input wire logic slow_in,
    output logic sample_end_out,
    output logic done_out,
    output logic [7:0] count_out
);
    timer_regs_t r_q;
    timer_regs_t r_d;
    logic [7:0] last;
    logic [7:0] smp_last;

    assign last = slow_in ? (`SLOW_CYC - 8'h01) : (`FAST_CYC - 8'h01);
    assign smp_last = slow_in ? (`SLOW_SMP - 8'h01) : (`FAST_SMP - 8'h01);
    assign done_out = run_in && (r_q.count == last);
    assign sample_end_out = run_in && (r_q.count == smp_last);
    assign count_out = r_q.count;

    always_comb
    begin
        r_d = r_q;
        // Restart from zero so continuous mode runs back to back
        if (!run_in || done_out)
            r_d.count = 8'h00;
        else
            r_d.count = r_q.count + 8'h01;
    end

    always_ff @(posedge mclk_in)
    begin
        if (srst_in)
            r_q <= '0;
        else
            r_q <= r_d;
    end
endmodule

//--- rtl/adc_conv_ctrl.sv
// Conversion control logic with its AXI4-Lite register slave
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "adc_conv_defs.svh"
module adc_conv_ctrl
    import adc_conv_pkg::*;
(
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [`ADDR_W-1:0] awaddr_in,
    input wire logic wvalid_in,
    output logic wready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    output logic bvalid_out,
    input wire logic bready_in,
    output logic [1:0] bresp_out,
    input wire logic arvalid_in,
    output logic arready_out,
    input wire logic [`ADDR_W-1:0] araddr_in,
    output logic rvalid_out,
    input wire logic rready_in,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    input wire logic [7:0] conv_data_in,
    input wire logic ext_trig_pin_in,
    input wire logic timer_event_in,
    input wire logic halt_in,
    input wire logic ext_irq_pin_in,
    output logic [2:0] channel_out,
    output logic sample_hold_out,
    output logic conv_busy_out,
    output logic analog_power_out,
    output logic irq_out
);
    // ****************************************
    // Decoding
    // ****************************************
    function automatic logic [1:0] reg_sel(input logic [`ADDR_W-1:0] a);
        reg_sel = 2'h3;
        if (a[`ADDR_W-1:10] == 2'h0)
        begin
            case (a[9:2])
                `IDX_RESULT: reg_sel = 2'h0;
                `IDX_CTRL: reg_sel = 2'h1;
                `IDX_INTSEL: reg_sel = 2'h2;
                default: reg_sel = 2'h3;
            endcase
        end
    endfunction

    function automatic logic [2:0] ch_map(input logic [2:0] code);
        case (code)
            3'h0: ch_map = 3'h0;
            3'h1: ch_map = 3'h1;
            3'h2: ch_map = 3'h2;
            3'h3: ch_map = 3'h4;
            3'h4: ch_map = 3'h3;
            default: ch_map = 3'h0;
        endcase
    endfunction

    // ****************************************
    // State
    // ****************************************
    ctl_regs_t s_q;
    ctl_regs_t s_d;
    logic tc;
    logic smp_end;
    logic [7:0] tmr_count;
    logic aw_hs;
    logic w_hs;
    logic wr_go;
    logic [1:0] wsel;
    logic [1:0] rsel;
    logic wr_ctrl;
    logic trig_hit;
    logic trig_en_w;

    conv_timer u_timer (
        .mclk_in(mclk_in),
        .srst_in(srst_in),
        .run_in(s_q.state != ST_IDLE),
        .slow_in(s_q.ctrl[`SPEED_BIT]),
        .sample_end_out(smp_end),
        .done_out(tc),
        .count_out(tmr_count)
    );

    always_comb
    begin
        s_d = s_q;
        s_d.trig_prev = ext_trig_pin_in;
        // ****************************************
        // Write channel
        // ****************************************
        aw_hs = awvalid_in && s_q.awready;
        w_hs = wvalid_in && s_q.wready;
        if (s_q.bvalid && bready_in)
            s_d.bvalid = 1'b0;
        if (aw_hs)
        begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = awaddr_in;
        end
        if (w_hs)
        begin
            s_d.w_have = 1'b1;
            s_d.w_byte = wdata_in[7:0];
            s_d.w_en = wstrb_in[0];
        end
        wr_go = s_d.aw_have && s_d.w_have;
        wsel = reg_sel(s_d.aw_addr);
        if (wr_go)
        begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = (wsel == 2'h3) ? `RESP_SLVERR : `RESP_OKAY;
        end
        wr_ctrl = wr_go && s_d.w_en && (wsel == 2'h1);

        // ****************************************
        // Sequencing
        // ****************************************
        if (wr_go && s_d.w_en && (wsel == 2'h0))
            s_d.result = s_d.w_byte;
        if (wr_go && s_d.w_en && (wsel == 2'h2))
            s_d.int_sel = s_d.w_byte[0];
        if (tc && !wr_ctrl)
        begin
            s_d.result = conv_data_in;
            if (!s_q.ctrl[`CONT_BIT])
            begin
                s_d.ctrl[`START_BIT] = 1'b0;
                s_d.state = ST_IDLE;
            end
            else
            begin
                s_d.state = ST_SAMPLE;
            end
        end
        else if (s_q.state == ST_SAMPLE && smp_end)
        begin
            s_d.state = ST_CONVERT;
        end
        else if (s_q.state == ST_IDLE && s_q.ctrl[`START_BIT])
        begin
            s_d.state = ST_SAMPLE;
        end
        // A control write wins over everything the sequencer did this cycle
        if (wr_ctrl)
        begin
            s_d.ctrl = s_d.w_byte;
            s_d.state = ST_IDLE;
        end
        // Stopping by software also ends a continuous run
        if (!s_d.ctrl[`START_BIT])
            s_d.state = ST_IDLE;
        // Triggers judge the enable just written but the flag as it stood
        trig_en_w = s_d.ctrl[`TRIG_EN_BIT];
        trig_hit = (s_q.trig_prev && !ext_trig_pin_in) || timer_event_in;
        if (trig_hit && trig_en_w && !s_q.ctrl[`START_BIT])
            s_d.ctrl[`START_BIT] = 1'b1;
        if (halt_in)
            s_d.ctrl[`POWER_BIT] = 1'b0;
        // Nothing sequences without analog power
        if (!s_d.ctrl[`POWER_BIT])
            s_d.state = ST_IDLE;

        // ****************************************
        // Read channel
        // ****************************************
        if (s_q.rvalid && rready_in)
            s_d.rvalid = 1'b0;
        rsel = reg_sel(araddr_in);
        if (arvalid_in && s_q.arready)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp = (rsel == 2'h3) ? `RESP_SLVERR : `RESP_OKAY;
            case (rsel)
                2'h0: s_d.rdata = s_q.result;
                2'h1: s_d.rdata = s_q.ctrl;
                2'h2: s_d.rdata = {7'h00, s_q.int_sel};
                default: s_d.rdata = 8'h00;
            endcase
        end
        s_d.awready = !s_d.aw_have && !s_d.bvalid;
        s_d.wready = !s_d.w_have && !s_d.bvalid;
        s_d.arready = !s_d.rvalid;

        // ****************************************
        // Outputs
        // ****************************************
        s_d.channel = ch_map(s_d.ctrl[`CH_MSB:`CH_LSB]);
        s_d.sample = (s_d.state == ST_SAMPLE);
        s_d.busy = (s_d.state != ST_IDLE);
        s_d.power = s_d.ctrl[`POWER_BIT];
        // With int_sel set, the interrupt is a one-cycle pulse on the falling start flag; otherwise it follows the external pin
        if (s_q.int_sel)
            s_d.irq = s_q.ctrl[`START_BIT] && !s_d.ctrl[`START_BIT];
        else
            s_d.irq = ext_irq_pin_in;
    end

    always_ff @(posedge mclk_in)
    begin
        if (srst_in)
        begin
            s_q <= '0;
            s_q.ctrl <= `CTRL_RST;
            s_q.int_sel <= `INTSEL_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign awready_out = s_q.awready;
    assign wready_out = s_q.wready;
    assign bvalid_out = s_q.bvalid;
    assign bresp_out = s_q.bresp;
    assign arready_out = s_q.arready;
    assign rvalid_out = s_q.rvalid;
    assign rdata_out = {24'h000000, s_q.rdata};
    assign rresp_out = s_q.rresp;
    assign channel_out = s_q.channel;
    assign sample_hold_out = s_q.sample;
    assign conv_busy_out = s_q.busy;
    assign analog_power_out = s_q.power;
    assign irq_out = s_q.irq;

    // ****************************************
    // Assertions
    // ****************************************
    logic [7:0] run_len_q;

    always_ff @(posedge mclk_in)
    begin
        if (srst_in || s_q.state == ST_IDLE || tc)
            run_len_q <= 8'h00;
        else
            run_len_q <= run_len_q + 8'h01;
    end

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (srst_in);

    property p_abort;
        wr_ctrl |=> (s_q.state == ST_IDLE && !sample_hold_out) ##1 tmr_count == 8'h00;
    endproperty
    a_abort: assert property (p_abort) else $error("control write did not abort");

    property p_chan;
        s_q.ctrl[7:5] == 3'h3 |-> channel_out == 3'h4;
    endproperty
    a_chan: assert property (p_chan) else $error("channel code 3 not mapped to input 4");

    property p_fast;
        tc && !s_q.ctrl[`SPEED_BIT] |-> run_len_q == 8'h4D;
    endproperty
    a_fast: assert property (p_fast) else $error("fast conversion not 78 cycles");

    property p_slow;
        tc && s_q.ctrl[`SPEED_BIT] |-> run_len_q == 8'h89;
    endproperty
    a_slow: assert property (p_slow) else $error("slow conversion not 138 cycles");

    property p_trig_off;
        trig_hit && !trig_en_w && !s_q.ctrl[0] && !wr_ctrl |=> !s_q.ctrl[0];
    endproperty
    a_trig_off: assert property (p_trig_off) else $error("disabled trigger set start flag");

    property p_trig_on;
        trig_hit && trig_en_w && !s_q.ctrl[0] |=> s_q.ctrl[0];
    endproperty
    a_trig_on: assert property (p_trig_on) else $error("enabled trigger did not set start flag");

    property p_single;
        tc && !wr_ctrl && !s_q.ctrl[`CONT_BIT] |=> !s_q.ctrl[0] && !conv_busy_out;
    endproperty
    a_single: assert property (p_single) else $error("single mode did not stop");

    property p_cont;
        tc && !wr_ctrl && !halt_in && s_q.ctrl[`CONT_BIT] |=> sample_hold_out && conv_busy_out;
    endproperty
    a_cont: assert property (p_cont) else $error("continuous mode did not restart");

    property p_irq;
        s_q.int_sel && s_q.ctrl[0] && !s_d.ctrl[0] |=> irq_out ##1 !irq_out || $fell(s_q.ctrl[0]);
    endproperty
    a_irq: assert property (p_irq) else $error("no interrupt on start flag fall");

    property p_route;
        !s_q.int_sel |=> irq_out == $past(ext_irq_pin_in);
    endproperty
    a_route: assert property (p_route) else $error("external pin not routed");

    property p_result;
        tc && !wr_ctrl |=> s_q.result == $past(conv_data_in);
    endproperty
    a_result: assert property (p_result) else $error("result not loaded");

    property p_halt;
        halt_in |=> !analog_power_out && !conv_busy_out;
    endproperty
    a_halt: assert property (p_halt) else $error("halt did not remove power");

    c_fast: cover property (tc && !s_q.ctrl[`SPEED_BIT]);
    c_slow: cover property (tc && s_q.ctrl[`SPEED_BIT]);
    c_cont: cover property (tc && s_q.ctrl[`CONT_BIT] ##1 sample_hold_out);
    c_trig: cover property (trig_hit && trig_en_w && !s_q.ctrl[0]);
endmodule

//--- tb/far_side.sv
// Far-side model: analog array answer and the two trigger sources
`timescale 1ns/1ps
module far_side (
    input wire logic mclk_in,
    input wire logic [2:0] ch_in,
    input wire logic busy_in,
    input wire logic power_in,
    input wire logic [7:0] lvl_in,
    input wire logic ext_in,
    input wire logic tmr_in,
    output logic [7:0] data_out,
    output logic pin_out,
    output logic event_out
);
    initial
    begin
        data_out = 8'h5A;
        pin_out = 1'b1;
        event_out = 1'b0;
    end
    // An idle or unpowered array gives a moving value, never a stale one
    // Ideal array settles in one clock, so the fast-mode clock ceiling never bites here
    always @(posedge mclk_in)
    begin
        if (busy_in && power_in)
            data_out <= lvl_in ^ {5'h00, ch_in};
        else
            data_out <= ~data_out;
        pin_out <= ~ext_in;
        event_out <= tmr_in;
    end
endmodule

//--- tb/tb_top.sv
// Self-checking bench of the conversion control block
`timescale 1ns/1ps
`include "adc_conv_defs.svh"
module tb_top;
    localparam logic [11:0] A_RES = {2'h0, `IDX_RESULT, 2'h0};
    localparam logic [11:0] A_CTL = {2'h0, `IDX_CTRL, 2'h0};
    localparam logic [11:0] A_SEL = {2'h0, `IDX_INTSEL, 2'h0};
    logic mclk_in = 1'b0;
    logic srst_in = 1'b1;
    logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic [11:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd_v, rnd = 32'h00015274;
    logic awr, wrdy, bv, arr, rv, sh, busy, apow, irq, tpin, tev;
    logic [1:0] br, rr;
    logic [2:0] ch;
    logic [7:0] cdata, lvl = 0;
    logic ext = 0, tmr = 0, halt = 0, xirq = 0;
    int fail_count = 0, checks_done = 0, irq_n = 0, cyc = 0;
    logic [1:0] bq[$];
    logic [33:0] rq[$];

    always #5 mclk_in = ~mclk_in;

    adc_conv_ctrl dut_u (
        .mclk_in(mclk_in), .srst_in(srst_in),
        .awvalid_in(awv), .awready_out(awr), .awaddr_in(awa),
        .wvalid_in(wv), .wready_out(wrdy), .wdata_in(wd),
        .wstrb_in(4'hF), .bvalid_out(bv), .bready_in(bready),
        .bresp_out(br), .arvalid_in(arv), .arready_out(arr),
        .araddr_in(ara), .rvalid_out(rv), .rready_in(rready),
        .rdata_out(rd_v), .rresp_out(rr), .conv_data_in(cdata),
        .ext_trig_pin_in(tpin), .timer_event_in(tev),
        .halt_in(halt), .ext_irq_pin_in(xirq), .channel_out(ch),
        .sample_hold_out(sh), .conv_busy_out(busy),
        .analog_power_out(apow), .irq_out(irq)
    );

    far_side far_u (
        .mclk_in(mclk_in), .ch_in(ch), .busy_in(busy),
        .power_in(apow), .lvl_in(lvl), .ext_in(ext), .tmr_in(tmr),
        .data_out(cdata), .pin_out(tpin), .event_out(tev)
    );

    // ********************
    // Bus and check tasks
    // ********************
    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction

    // Analog input that a channel code selects
    function automatic logic [2:0] exp_ch(input logic [2:0] c);
        case (c)
            3'h3: return 3'h4;
            3'h4: return 3'h3;
            default: return c;
        endcase
    endfunction

    task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
        checks_done++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic clk(input int n);
        repeat (n) @(posedge mclk_in);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Upper data bits are random: the slave must ignore them
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        logic [31:0] x;
        bit ta, tw;
        x = xs();
        bq.push_back(r);
        awv <= 1'b1;
        awa <= a;
        wv <= 1'b1;
        wd <= {x[31:8], d};
        ta = 0;
        tw = 0;
        while (!(ta && tw))
        begin
            @(posedge mclk_in);
            ta = ta | awr;
            tw = tw | wrdy;
            awv <= !ta;
            wv <= !tw;
        end
        bready <= 1'b1;
        @(posedge mclk_in);
        while (!bv) @(posedge mclk_in);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        rq.push_back({r, 24'h0, d});
        arv <= 1'b1;
        ara <= a;
        @(posedge mclk_in);
        while (!arr) @(posedge mclk_in);
        arv <= 1'b0;
        rready <= 1'b1;
        @(posedge mclk_in);
        while (!rv) @(posedge mclk_in);
        rready <= 1'b0;
    endtask

    task automatic span(input int nb, input int ns);
        int b, s;
        b = 0;
        s = 0;
        while (!busy) @(posedge mclk_in);
        while (busy)
        begin
            b++;
            s = s + int'(sh);
            @(posedge mclk_in);
        end
        chk("busy_len", nb, b);
        chk("sample_len", ns, s);
    endtask

    task automatic pulse(input bit e);
        if (e)
            ext <= 1'b1;
        else
            tmr <= 1'b1;
        clk(2);
        ext <= 1'b0;
        tmr <= 1'b0;
    endtask

    always @(posedge mclk_in)
    begin
        cyc++;
        if (irq)
            irq_n++;
        if (bv && bready)
            chk("bresp", {32'h0, bq.pop_front()}, {32'h0, br});
        if (rv && rready)
            chk("rdata", rq.pop_front(), {rr, rd_v});
        if (cyc > 30000)
        begin
            fail_count++;
            summarize();
        end
    end

    // ********************
    // Main sequence
    // ********************
    initial
    begin
        logic [31:0] x;
        logic [7:0] v;
        int k, n0;
        clk(8);
        srst_in <= 1'b0;
        clk(1);
        rd(A_CTL, `CTRL_RST, `RESP_OKAY);
        rd(A_SEL, 8'h01, `RESP_OKAY);
        wr({2'h0, 8'hF3, 2'h0}, 8'hFF, `RESP_SLVERR);
        rd(12'hBC4, 8'h00, `RESP_SLVERR);
        for (k = 0; k < 5; k++)
        begin
            x = xs();
            v = {k[2:0], x[4:0] & 5'h1A};
            wr(A_CTL, v, `RESP_OKAY);
            rd(A_CTL, v, `RESP_OKAY);
            chk("channel", {31'h0, exp_ch(k[2:0])}, {31'h0, ch});
            chk("power", 0, {33'h0, apow});
        end
        wr(A_CTL, 8'h01, `RESP_OKAY);
        clk(20);
        chk("busy_off", 0, {33'h0, busy});
        x = xs();
        lvl <= x[7:0];
        wr(A_CTL, 8'h04, `RESP_OKAY);
        clk(6000);
        n0 = irq_n;
        wr(A_CTL, 8'h25, `RESP_OKAY);
        span(78, 48);
        clk(2);
        rd(A_CTL, 8'h24, `RESP_OKAY);
        rd(A_RES, lvl ^ 8'h01, `RESP_OKAY);
        chk("irq_count", n0 + 1, irq_n);
        wr(A_CTL, 8'h95, `RESP_OKAY);
        span(138, 84);
        rd(A_RES, lvl ^ 8'h03, `RESP_OKAY);
        wr(A_CTL, 8'h04, `RESP_OKAY);
        pulse(1'b1);
        clk(10);
        chk("busy_notrig", 0, {33'h0, busy});
        wr(A_CTL, 8'h0C, `RESP_OKAY);
        pulse(1'b0);
        span(78, 48);
        pulse(1'b0);
        clk(30);
        pulse(1'b1);
        while (busy) clk(1);
        clk(5);
        chk("busy_retrig", 0, {33'h0, busy});
        rd(A_CTL, 8'h0C, `RESP_OKAY);
        n0 = irq_n;
        wr(A_CTL, 8'h0F, `RESP_OKAY);
        clk(5);
        k = 0;
        repeat (300)
        begin
            k = k + int'(busy);
            clk(1);
        end
        chk("cont_busy", 300, k);
        pulse(1'b1);
        rd(A_CTL, 8'h0F, `RESP_OKAY);
        rd(A_RES, lvl, `RESP_OKAY);
        wr(A_CTL, 8'h0E, `RESP_OKAY);
        clk(3);
        chk("busy_stop", 0, {33'h0, busy});
        chk("irq_stop", n0 + 1, irq_n);
        v = lvl;
        lvl <= ~lvl;
        wr(A_CTL, 8'h15, `RESP_OKAY);
        clk(40);
        wr(A_CTL, 8'h04, `RESP_OKAY);
        clk(3);
        chk("busy_abort", 0, {33'h0, busy});
        rd(A_RES, v, `RESP_OKAY);
        halt <= 1'b1;
        clk(3);
        chk("halt_power", 0, {33'h0, apow});
        halt <= 1'b0;
        rd(A_CTL, 8'h00, `RESP_OKAY);
        wr(A_SEL, 8'h00, `RESP_OKAY);
        xirq <= 1'b1;
        clk(2);
        chk("irq_pin", 1, {33'h0, irq});
        xirq <= 1'b0;
        clk(2);
        chk("irq_pin", 0, {33'h0, irq});
        rd(A_SEL, 8'h00, `RESP_OKAY);
        summarize();
    end
endmodule
